// [design/otr_cfg.svh]
// Purpose: named offsets, field positions, reset values and scale figures
// Assumes: 32-bit Avalon-MM data word, 16-bit trim registers in the low half
// Notes:   definitions only; included by bare name
`ifndef OTR_CFG_SVH
`define OTR_CFG_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define OTR_IDX_RSVD     4'h1
`define OTR_IDX_OFS      4'h2
`define OTR_IDX_RNG      4'h3
`define OTR_IDX_OFS_EFF  4'h8
`define OTR_IDX_SPAN     4'h9
`define OTR_IDX_CTRL     4'hf
`define OTR_IDX_LSB      2
`define OTR_IDX_MSB      5

// ****************************************
// reset values
// ****************************************
`define OTR_RST_RSVD     16'h2907
`define OTR_RST_OFS      16'h0000
`define OTR_RST_RNG      16'h4000
`define OTR_RST_CTRL     16'h0000

// ****************************************
// field positions
// ****************************************
`define OTR_OFS_SIGN_BIT 12
`define OTR_OFS_MAG_MSB  11
`define OTR_RNG_MSB      14
`define OTR_XMODE_BIT    0
`define OTR_LANES_LOW    4'h3

// ****************************************
// scale figures
// ****************************************
`define OTR_OFS_MAX_UV   28'h000afc8
`define OTR_OFS_MAX_CODE 28'h0000fff
`define OTR_RNG_MIN_MV   11'h258
`define OTR_RNG_STEP_MV  24'h000190
`define OTR_RNG_MAX_CODE 24'h007fff
`define OTR_RNG_NOM_MV   11'h320

`endif

// [design/otr_pkg.sv]
// Purpose: shared types of the offset and full-scale trim block
// Assumes: constants live in otr_cfg.svh
// Notes:   types only
package otr_pkg;
  typedef logic [15:0]        otr_word_t;     // one trim register
  typedef logic [3:0]         otr_idx_t;      // register index
  typedef logic signed [12:0] otr_ofs_code_t; // signed offset code
  typedef logic signed [17:0] otr_ofs_uv_t;   // signed offset in microvolts
  typedef logic [10:0]        otr_mv_t;       // span in millivolts
endpackage

// [design/otr_offset_map.sv]
// Purpose: turn the offset register into a signed code and microvolts
// Assumes: polarity in bit 12, magnitude in bits 11:0
// Notes:   outputs registered; one cycle behind the register
`timescale 1ns/10ps
`include "otr_cfg.svh"
module otr_offset_map
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire otr_pkg::otr_word_t offset_word,
  output otr_pkg::otr_ofs_code_t  offset_code,
  output otr_pkg::otr_ofs_uv_t    offset_uv
);
  import otr_pkg::*;

  // ****************************************
  // decode
  // ****************************************
  wire              offset_polarity = offset_word[`OTR_OFS_SIGN_BIT];     // 1 = subtract
  wire [11:0]       offset_level    = offset_word[`OTR_OFS_MAG_MSB:0];    // straight binary
  wire [27:0]       uv_prod         = {16'h0000, offset_level} * `OTR_OFS_MAX_UV;
  wire [27:0]       uv_quot         = uv_prod / `OTR_OFS_MAX_CODE;        // full code = 45 mV
  wire signed [17:0] uv_mag         = $signed({1'b0, uv_quot[16:0]});
  wire signed [12:0] code_mag       = $signed({1'b0, offset_level});
  // polarity picks the direction of the same magnitude
  wire otr_ofs_code_t code_next     = offset_polarity ? -code_mag : code_mag;
  wire otr_ofs_uv_t   uv_next       = offset_polarity ? -uv_mag : uv_mag;

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      offset_code <= '0;
      offset_uv   <= '0;
    end
    else
    begin
      offset_code <= code_next;
      offset_uv   <= uv_next;
    end
  end
endmodule

// [design/otr_range_map.sv]
// Purpose: turn the full-scale register into a span in millivolts
// Assumes: code in bits 14:0; extended mode flag from the control register
// Notes:   outside extended mode the span is capped at the nominal 800 mV ceiling
`timescale 1ns/10ps
`include "otr_cfg.svh"
module otr_range_map
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire otr_pkg::otr_word_t range_word,
  input  wire logic               extended_control_mode,
  output otr_pkg::otr_mv_t        full_scale_span
);
  import otr_pkg::*;

  // ****************************************
  // linear map 0 -> 600 mV, full code -> 1000 mV
  // ****************************************
  wire [14:0]   range_level = range_word[`OTR_RNG_MSB:0];
  wire [23:0]   span_prod   = {9'h000, range_level} * `OTR_RNG_STEP_MV;
  wire [23:0]   span_quot   = span_prod / `OTR_RNG_MAX_CODE;
  wire otr_mv_t span_lin    = `OTR_RNG_MIN_MV + span_quot[10:0];
  // spans above nominal exist only in extended mode
  wire          over_nom    = span_lin > `OTR_RNG_NOM_MV;
  wire otr_mv_t span_next   = (!extended_control_mode && over_nom) ? `OTR_RNG_NOM_MV : span_lin;

  // ****************************************
  // output register (reset span matches reset code)
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      full_scale_span <= `OTR_RNG_NOM_MV;
    else
      full_scale_span <= span_next;
  end
endmodule

// [design/otr_trim_regs.sv]
// Purpose: Avalon-MM register file for I-channel offset and full-scale trim
// Assumes: byte addressing, 32-bit data, trim words in the low 16 bits
// Notes:   every access takes one wait cycle; writes land when waitrequest is low
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "otr_cfg.svh"

// Function
// - offset bit 12 selects offset sign
// - offset bits 11:0 unsigned magnitude, 45 mV
// - offset register resets to zero
// - range code maps 600 to 1000 mV
// - range register resets to 16384, 800 mV
// - spans above 800 mV only in extended mode
module otr_trim_regs
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // avalon-mm slave
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [3:0]         avs_byteenable,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // trim results toward the converter
  output otr_pkg::otr_ofs_code_t  offset_code,
  output otr_pkg::otr_ofs_uv_t    offset_uv,
  output otr_pkg::otr_mv_t        full_scale_span,
  output logic                    extended_control_mode
);
  import otr_pkg::*;

  // ****************************************
  // helpers
  // ****************************************

  // true when the request points at the given register index
  function automatic logic idx_hit(input otr_idx_t idx, input otr_idx_t want);
    idx_hit = (idx == want);
  endfunction

  // ****************************************
  // state
  // ****************************************
  otr_word_t   rsvd_reg;          // reserved word, kept as written
  otr_word_t   offset_reg;        // offset polarity and level
  otr_word_t   range_reg;         // full-scale code
  otr_word_t   ctrl_reg;          // extended control mode flag
  logic        ack_reg;           // answer phase of the current access
  logic [31:0] rdata_reg;         // captured read data
  logic        ack_next;          // next answer phase
  logic [31:0] rdata_next;        // next read data

  // ****************************************
  // bus decode
  // ****************************************
  wire otr_idx_t idx      = avs_address[`OTR_IDX_MSB:`OTR_IDX_LSB];
  wire           req      = avs_read | avs_write;          // master request
  // a write counts only in its answer cycle, when waitrequest is low
  wire           wr_go    = avs_write & ack_reg;
  // both low byte lanes needed; a write missing either of them never touches the trims
  wire           full_wr  = (avs_byteenable & `OTR_LANES_LOW) == `OTR_LANES_LOW;
  wire           wr_take  = wr_go & full_wr;
  // one compare per register; address bits 1:0 never take part
  wire           hit_rsvd = idx_hit(idx, `OTR_IDX_RSVD);
  wire           hit_ofs  = idx_hit(idx, `OTR_IDX_OFS);
  wire           hit_rng  = idx_hit(idx, `OTR_IDX_RNG);
  wire           hit_eff  = idx_hit(idx, `OTR_IDX_OFS_EFF);
  wire           hit_span = idx_hit(idx, `OTR_IDX_SPAN);
  wire           hit_ctrl = idx_hit(idx, `OTR_IDX_CTRL);
  wire otr_word_t wword   = avs_writedata[15:0];           // trim word lane

  // ****************************************
  // read mux (unmapped reads return zero)
  // ****************************************
  // the status words show the trims as the converter sees them now
  // reading a status word never disturbs the trims
  wire [15:0] eff_word  = {{3{offset_code[12]}}, offset_code};
  wire [15:0] span_word = {5'h00, full_scale_span};
  wire [15:0] rd_low    = hit_rsvd ? rsvd_reg   :
                          hit_ofs  ? offset_reg :
                          hit_rng  ? range_reg  :
                          hit_eff  ? eff_word   :
                          hit_span ? span_word  :
                          hit_ctrl ? ctrl_reg   : 16'h0000;

  // ****************************************
  // handshake
  // ****************************************
  // first cycle of a request always waits; the second answers
  // a fixed single wait halves the bus rate but keeps the answer timing trivial
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // answer phase toggles once per request, then drops
  assign ack_next   = req & ~ack_reg;
  // read data are captured in the wait cycle and held through the answer
  assign rdata_next = (avs_read & ~ack_reg) ? {16'h0000, rd_low} : rdata_reg;

  // handshake registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // trim registers
  // ****************************************

  // reserved word: stored as written, the host keeps the pattern
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rsvd_reg <= `OTR_RST_RSVD;
    else if (wr_take && hit_rsvd)
      rsvd_reg <= wword;
  end

  // offset word: zero after reset means no added offset
  // bits 15:13 are stored as written; the offset map ignores them
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      offset_reg <= `OTR_RST_OFS;
    else if (wr_take && hit_ofs)
      offset_reg <= wword;
  end

  // full-scale word: reset code is the nominal span
  // bit 15 is stored as written; the span map ignores it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      range_reg <= `OTR_RST_RNG;
    else if (wr_take && hit_rng)
      range_reg <= wword;
  end

  // control word: only the mode bit has meaning
  // the other control bits are stored and read back with no effect
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_reg <= `OTR_RST_CTRL;
    else if (wr_take && hit_ctrl)
      ctrl_reg <= wword;
  end

  // mode flag as seen by the span map
  assign extended_control_mode = ctrl_reg[`OTR_XMODE_BIT];

  // ****************************************
  // trim maps
  // ****************************************

  // both maps register their result, so trims trail their register by one cycle
  // the status word at index 8 shows the offset code sign-extended
  // signed offset; upper bits 15:13 are ignored, so a careless host
  // still gets a sane offset
  otr_offset_map u_offset_map
  (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .offset_word (offset_reg),
    .offset_code (offset_code),
    .offset_uv   (offset_uv)
  );

  // full-scale span; bit 15 ignored for the same reason
  otr_range_map u_range_map
  (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .range_word            (range_reg),
    .extended_control_mode (extended_control_mode),
    .full_scale_span       (full_scale_span)
  );

  // ****************************************
  // assertions
  // ****************************************
  // checks watch what this block drives; trim state, reset or bus inputs start them, and in the write checks the written word is also the expected value
  // each failure message names the broken behaviour, not the signal

  // polarity bit flips the direction of the offset code
  AST_OFS_SIGN: assert property (
    @(posedge clk_sys) disable iff (rst)
    offset_reg[`OTR_OFS_SIGN_BIT] && (offset_reg[`OTR_OFS_MAG_MSB:0] != 12'h000)
      ##1 $stable(offset_reg) |-> (offset_code < 13'sh0000) && (offset_uv < 18'sh00000))
    else $error("negative polarity did not give a negative offset");

  // full magnitude gives exactly 45 mV
  AST_OFS_MAG: assert property (
    @(posedge clk_sys) disable iff (rst)
    (offset_reg[`OTR_OFS_SIGN_BIT:0] == 13'h0fff) |=> (offset_uv == 18'sh0afc8))
    else $error("full offset magnitude is not 45 mV");

  // offset word is zero as reset releases, and the output carries none
  AST_OFS_RESET: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> (offset_reg == 16'h0000) && (offset_uv == 18'sh00000))
    else $error("offset not cleared by reset");

  // full range code gives 1000 mV in extended mode
  AST_RNG_LIN: assert property (
    @(posedge clk_sys) disable iff (rst)
    extended_control_mode && (range_reg[`OTR_RNG_MSB:0] == 15'h7fff) |=> (full_scale_span == 11'h3e8))
    else $error("full range code is not 1000 mV");

  // range word holds 16384 at reset release and gives 800 mV
  AST_RNG_RST: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> (range_reg == 16'h4000) && (full_scale_span == 11'h320))
    else $error("range not at nominal after reset");

  // normal mode never exceeds 800 mV
  AST_RNG_XMODE: assert property (
    @(posedge clk_sys) disable iff (rst)
    !extended_control_mode ##1 !extended_control_mode |-> (full_scale_span <= 11'h320))
    else $error("span above 800 mV outside extended mode");

  // a write missing either low byte lane leaves both trims untouched
  AST_PARTIAL: assert property (
    @(posedge clk_sys) disable iff (rst)
    avs_write && !avs_waitrequest && !full_wr |=> $stable(offset_reg) && $stable(range_reg))
    else $error("partial write changed a trim");

  // every request is answered one cycle after it starts
  AST_ANSWER: assert property (
    @(posedge clk_sys) disable iff (rst)
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one wait cycle");

  // a complete offset write lands exactly as written
  AST_OFS_WR: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_take && hit_ofs |=> (offset_reg == $past(wword)))
    else $error("complete offset write did not land");

  // a complete range write lands exactly as written
  AST_RNG_WR: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_take && hit_rng |=> (range_reg == $past(wword)))
    else $error("complete range write did not land");

  // zero magnitude is no offset whatever the polarity bit says
  AST_OFS_ZERO: assert property (
    @(posedge clk_sys) disable iff (rst)
    (offset_reg[`OTR_OFS_MAG_MSB:0] == 12'h000) |=> (offset_code == 13'sh0000) && (offset_uv == 18'sh00000))
    else $error("zero magnitude gave an offset");

  // the mid range code gives the nominal span in either mode
  AST_RNG_MID: assert property (
    @(posedge clk_sys) disable iff (rst)
    (range_reg[`OTR_RNG_MSB:0] == 15'h4000) |=> (full_scale_span == 11'h320))
    else $error("mid range code is not the nominal span");

  // extended mode is off as reset releases, so the span starts clamped
  AST_XMODE_RST: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> !extended_control_mode)
    else $error("extended mode set after reset");

  // read data stay put for the cycle after the answer edge
  AST_RD_HOLD: assert property (
    @(posedge clk_sys) disable iff (rst)
    avs_read && !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved after the answer");

  // the offset word reads back as it is stored
  AST_RD_OFS: assert property (
    @(posedge clk_sys) disable iff (rst)
    avs_read && !avs_waitrequest && hit_ofs |-> (avs_readdata == {16'h0000, offset_reg}))
    else $error("offset word read back wrong");

  // the range word reads back as it is stored
  AST_RD_RNG: assert property (
    @(posedge clk_sys) disable iff (rst)
    avs_read && !avs_waitrequest && hit_rng |-> (avs_readdata == {16'h0000, range_reg}))
    else $error("range word read back wrong");

  // main scenarios
  COV_NEG_OFS: cover property (@(posedge clk_sys) disable iff (rst)
    wr_take && hit_ofs && wword[`OTR_OFS_SIGN_BIT]);
  COV_XMODE_SPAN: cover property (@(posedge clk_sys) disable iff (rst)
    extended_control_mode && (full_scale_span > 11'h320));
  COV_PART_WR: cover property (@(posedge clk_sys) disable iff (rst)
    wr_go && !full_wr);
  COV_MID_SPAN: cover property (@(posedge clk_sys) disable iff (rst)
    extended_control_mode && (range_reg[`OTR_RNG_MSB:0] == 15'h4000));
endmodule

// [verif/tb.sv]
// Purpose: self-checking bench for the offset and full-scale trim register file
// Assumes: one-wait Avalon-MM slave; trim outputs follow their register one cycle later
// Notes:   expected values are worked out here from the scale figures, not from outputs
`timescale 1ns/10ps
`include "otr_cfg.svh"
module tb;
  import otr_pkg::*;

  // ****************************************
  // stimulus and observation signals
  // ****************************************
  logic                  clk_sys;          // 100 MHz system clock
  logic                  rst;              // async reset, active high
  logic [5:0]            avs_address;      // byte address
  logic                  avs_read;         // read request
  logic                  avs_write;        // write request
  logic [3:0]            avs_byteenable;   // byte lanes
  logic [31:0]           avs_writedata;    // write data
  logic [31:0]           avs_readdata;     // read data
  logic                  avs_waitrequest;  // slave stall
  otr_ofs_code_t         offset_code;      // signed offset code
  otr_ofs_uv_t           offset_uv;        // signed offset in microvolts
  otr_mv_t               full_scale_span;  // span in millivolts
  logic                  extended_control_mode; // widened range enable
  int                    err_total;        // mismatches seen
  int                    compares;         // comparisons made
  int                    cyc = 0;          // cycle counter for the hang guard
  logic [31:0]           rdata;            // last read result
  logic [15:0]           codes [4];        // range codes under test
  logic [31:0]           spans [2][4];     // expected span per mode and code

  otr_trim_regs DUT
  (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_byteenable        (avs_byteenable),
    .avs_writedata         (avs_writedata),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .offset_code           (offset_code),
    .offset_uv             (offset_uv),
    .full_scale_span       (full_scale_span),
    .extended_control_mode (extended_control_mode)
  );

  // clock: invert every half period
  always #5 clk_sys = ~clk_sys;

  // ****************************************
  // closing report and hang guard
  // ****************************************
  task automatic wrap_up;
    $display("errors %0d of %0d comparisons", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles, so 3000 means a hang
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      $display("mismatch t=%0t bus hang", $time);
      wrap_up();
    end
  end

  // ****************************************
  // comparison and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // write: held until waitrequest is sampled low, released only after that edge
  task automatic bus_write(input logic [5:0] addr, input logic [15:0] data, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= addr;
    avs_writedata  <= {16'h0000, data};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask

  // read: data taken at the same edge that sees waitrequest low
  task automatic bus_read(input logic [5:0] addr, output logic [31:0] data);
    @(posedge clk_sys);
    avs_address <= addr;
    avs_read    <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    data = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] addr, input logic [31:0] exp);
    bus_read(addr, rdata);
    chk(rdata, exp);
  endtask

  // let the register update and the one-cycle trim stage land before looking
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h00000000;
    err_total = 0;
    compares = 0;
    codes = '{16'h0000, 16'h2000, 16'h4000, 16'h7fff};
    // normal mode tops out at 800 mV; extended mode reaches 1000 mV
    spans = '{'{32'h258, 32'h2bc, 32'h320, 32'h320}, '{32'h258, 32'h2bc, 32'h320, 32'h3e8}};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    // reset state of the trim outputs and registers
    chk(32'(offset_code), 32'h00000000);
    chk(32'(offset_uv), 32'h00000000);
    chk(32'(full_scale_span), 32'h00000320);
    chk(32'(extended_control_mode), 32'h00000000);
    rd_chk(6'h04, 32'h00002907);
    rd_chk(6'h08, 32'h00000000);
    rd_chk(6'h0c, 32'h00004000);
    rd_chk(6'h3c, 32'h00000000);
    // host keeps the reserved pattern when it rewrites that word
    bus_write(6'h04, 16'h2907, 4'hf);
    rd_chk(6'h04, 32'h00002907);
    // full positive magnitude, upper bits written as zero
    bus_write(6'h08, 16'h0fff, 4'hf);
    settle();
    chk(32'(offset_code), 32'h00000fff);
    chk(32'(offset_uv), 32'h0000afc8);
    // incomplete words must leave the trim alone
    bus_write(6'h08, 16'h1800, 4'h1);
    bus_write(6'h08, 16'h1800, 4'h2);
    bus_write(6'h08, 16'h1800, 4'hc);
    settle();
    chk(32'(offset_code), 32'h00000fff);
    rd_chk(6'h08, 32'h00000fff);
    // polarity bit set: mid magnitude applied negatively, floor of 2048*45000/4095
    bus_write(6'h08, 16'h1800, 4'hf);
    settle();
    chk(32'(offset_code), 32'hfffff800);
    chk(32'(offset_uv), 32'hffffa817);
    rd_chk(6'h20, 32'h0000f800);
    rd_chk(6'h08, 32'h00001800);
    // range codes in normal then extended mode
    for (int m = 0; m < 2; m++)
    begin
      bus_write(6'h3c, 16'(m), 4'hf);
      for (int k = 0; k < 4; k++)
      begin
        bus_write(6'h0c, codes[k], 4'hf);
        settle();
        chk(32'(full_scale_span), spans[m][k]);
        chk(32'(extended_control_mode), 32'(m));
      end
    end
    // partial range write ignored; span stays at the 1000 mV top
    bus_write(6'h0c, 16'h0000, 4'he);
    settle();
    chk(32'(full_scale_span), 32'h000003e8);
    // unmapped place reads zero, read-only span ignores writes
    bus_write(6'h14, 16'hffff, 4'hf);
    rd_chk(6'h14, 32'h00000000);
    bus_write(6'h24, 16'h0000, 4'hf);
    rd_chk(6'h24, 32'h000003e8);
    // leaving extended mode pulls the span back to the nominal ceiling
    bus_write(6'h3c, 16'h0000, 4'hf);
    settle();
    chk(32'(full_scale_span), 32'h00000320);
    wrap_up();
  end
endmodule
